// [dcw_pkg.sv]
// How it works
// - Words are 16 data bits plus parity
// - Split function, modifier, subscript, parameter fields
// - Odd parity on commands and responses
// - Reserved function codes are rejected
// - Subscript is unsigned 0 to 255
// - Magnetic function code map
// - Optical function code map
// - Status requests return a 17-bit word
// - Modifier selects the returned word
// - Reserved response fields left to the word's source to zero
// - Magnetic seek: cylinder, offsets cleared
// - Optical absolute seek uses stored high bits
// - Optical distance seek uses stored direction
// - MSB first, one bit per handshake
// - Parity one when ones count even
// - Start ignored unless command complete
package dcw_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS  = 16;
  localparam int FRAME_BITS = 17;
  localparam int FUNC_MSB   = 15;
  localparam int FUNC_LSB   = 12;
  localparam int MOD_MSB    = 11;
  localparam int MOD_LSB    = 8;
  localparam int SUB_MSB    = 7;
  localparam int PARM_MSB   = 11;
  localparam int DIR_LSB    = 8;
  localparam logic [4:0] BITS_RESET = 5'h00;
  localparam logic [4:0] BITS_LAST  = 5'h10;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DCW_SEEK      = 4'h0,
    DCW_RECAL     = 4'h1,
    DCW_REQ_STAT  = 4'h2,
    DCW_REQ_CFG   = 4'h3,
    DCW_HEAD_GRP  = 4'h4,
    DCW_CONTROL   = 4'h5,
    DCW_STROBE    = 4'h6,
    DCW_TRK_OFS   = 4'h7,
    DCW_DIAG      = 4'h8,
    DCW_BPS       = 4'h9,
    DCW_SET_HIGH  = 4'ha,
    DCW_FORMAT    = 4'hb,
    DCW_RSV_C     = 4'hc,
    DCW_RSV_D     = 4'hd,
    DCW_SET_CFG   = 4'he,
    DCW_LINK      = 4'hf
  } dcw_func_t;

  // Decoded command as handed to the drive control
  typedef struct packed {
    dcw_func_t   func;
    logic [3:0]  modifier;
    logic [7:0]  subscript;
    logic [11:0] parameter_f;
  } dcw_cmd_t;

  // Seek target as handed to the servo
  typedef struct packed {
    logic [15:0] target;
    logic [1:0]  direction;
    logic        clear_offsets;
  } dcw_seek_t;

  // Odd parity bit: one when the count of ones is even
  function automatic logic dcw_parity(input logic [15:0] w);
    dcw_parity = ~(^w);
  endfunction : dcw_parity

endpackage : dcw_pkg

// [dcw_resp_tx.sv]
`timescale 1ns/100ps
module dcw_resp_tx (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [15:0] word,
  input  wire logic        bit_take,
  output logic             bit_out,
  output logic             busy,
  output logic             done
);

  // ----------------------------------------------------------------
  // Response shifter
  // ----------------------------------------------------------------
  logic [16:0] shift_reg;
  logic [4:0]  cnt_reg;
  logic        busy_reg;
  logic        done_reg;

  wire logic last_bit = (cnt_reg == dcw_pkg::BITS_LAST);

  // Parity appended below bit 0, sent MSB first
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_reg <= 17'h00000;
      cnt_reg   <= dcw_pkg::BITS_RESET;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (load && !busy_reg)
      begin
        shift_reg <= {word, dcw_pkg::dcw_parity(word)};
        cnt_reg   <= dcw_pkg::BITS_RESET;
        busy_reg  <= 1'b1;
      end
      else if (busy_reg && bit_take)
      begin
        shift_reg <= {shift_reg[15:0], 1'b0};
        cnt_reg   <= cnt_reg + 5'h01;
        if (last_bit)
        begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign bit_out = shift_reg[16];
  assign busy    = busy_reg;
  assign done    = done_reg;

endmodule : dcw_resp_tx

// [dcw_decoder.sv]
`timescale 1ns/100ps
module dcw_decoder (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              optical_mode,
  input  wire logic              cmd_data_pin,
  input  wire logic              xfer_req_pin,
  output logic                   xfer_ack,
  output logic                   status_data,
  input  wire logic              drive_ready,
  input  wire logic [15:0]       resp_word,
  output logic                   resp_sel_valid,
  output logic [3:0]             resp_sel,
  output logic [7:0]             resp_sub,
  output logic                   cmd_complete,
  output logic                   cmd_valid,
  output dcw_pkg::dcw_cmd_t      cmd_out,
  output logic                   cmd_invalid,
  output logic                   parity_error,
  output logic                   seek_valid,
  output dcw_pkg::dcw_seek_t     seek_out,
  output logic [3:0]             high_bits,
  output logic [1:0]             high_dir
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] data_sync_reg;
  logic [1:0] req_sync_reg;
  logic       req_prev_reg;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_sync_reg <= 2'h0;
      req_sync_reg  <= 2'h0;
      req_prev_reg  <= 1'b0;
    end
    else
    begin
      data_sync_reg <= {data_sync_reg[0], cmd_data_pin};
      req_sync_reg  <= {req_sync_reg[0], xfer_req_pin};
      req_prev_reg  <= req_sync_reg[1];
    end
  end

  wire logic data_s   = data_sync_reg[1];
  wire logic req_rise = req_sync_reg[1] && !req_prev_reg;
  wire logic req_fall = !req_sync_reg[1] && req_prev_reg;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DCW_IDLE = 5'h01,
    DCW_RECV = 5'h02,
    DCW_EXEC = 5'h04,
    DCW_RESP = 5'h08,
    DCW_WAIT = 5'h10
  } dcw_state_t;

  dcw_state_t  state_reg;
  dcw_state_t  state_next;
  logic [16:0] rx_reg;
  logic [4:0]  cnt_reg;
  logic        ack_reg;
  logic        arm_reg;
  logic [3:0]  high_reg;
  logic [1:0]  dir_reg;

  // Received fields
  wire logic [15:0] rx_word   = rx_reg[16:1];
  wire logic        rx_par    = rx_reg[0];
  wire dcw_pkg::dcw_func_t func =
    dcw_pkg::dcw_func_t'(rx_word[dcw_pkg::FUNC_MSB:dcw_pkg::FUNC_LSB]);
  wire logic [3:0]  modif     = rx_word[dcw_pkg::MOD_MSB:dcw_pkg::MOD_LSB];
  wire logic [7:0]  subsc     = rx_word[dcw_pkg::SUB_MSB:0];
  wire logic [11:0] parm      = rx_word[dcw_pkg::PARM_MSB:0];
  wire logic        last_bit  = (cnt_reg == dcw_pkg::BITS_LAST);

  // Reserved codes differ per variant
  wire logic rsv_mag = (func == dcw_pkg::DCW_FORMAT) ||
                       (func == dcw_pkg::DCW_RSV_C) ||
                       (func == dcw_pkg::DCW_RSV_D) ||
                       (func == dcw_pkg::DCW_LINK);
  wire logic rsv_opt = (func == dcw_pkg::DCW_HEAD_GRP) ||
                       (func == dcw_pkg::DCW_BPS) ||
                       (func == dcw_pkg::DCW_RSV_C) ||
                       (func == dcw_pkg::DCW_RSV_D) ||
                       (func == dcw_pkg::DCW_LINK);
  wire logic reserved = optical_mode ? rsv_opt : rsv_mag;
  wire logic par_bad  = (rx_par != dcw_pkg::dcw_parity(rx_word));
  wire logic reject   = reserved || par_bad;
  wire logic is_req   = (func == dcw_pkg::DCW_REQ_STAT) ||
                        (func == dcw_pkg::DCW_REQ_CFG);

  // Response shifter handshake
  logic tx_busy;
  logic tx_done;
  logic tx_bit;
  wire logic tx_load = (state_reg == DCW_EXEC) && !reject && is_req;
  // Bit stays put while ack is high; it moves on when the host lets go
  wire logic tx_take = (state_reg == DCW_RESP) && req_fall && arm_reg;

  dcw_resp_tx u_resp_tx (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .load     (tx_load),
    .word     (resp_word),
    .bit_take (tx_take),
    .bit_out  (tx_bit),
    .busy     (tx_busy),
    .done     (tx_done)
  );

  // Next state; a request while busy is simply not seen
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DCW_IDLE: if (req_rise && drive_ready) state_next = DCW_RECV;
      DCW_RECV: if (req_rise && last_bit) state_next = DCW_EXEC;
      DCW_EXEC: state_next = tx_load ? DCW_RESP : DCW_WAIT;
      DCW_RESP: if (tx_done) state_next = DCW_WAIT;
      DCW_WAIT: if (!req_sync_reg[1]) state_next = DCW_IDLE;
    endcase
  end

  // Shift in, one bit per request edge, MSB first
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= DCW_IDLE;
      rx_reg    <= 17'h00000;
      cnt_reg   <= dcw_pkg::BITS_RESET;
      ack_reg   <= 1'b0;
      arm_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (req_rise && (state_next == DCW_RECV || state_reg == DCW_RECV))
      begin
        rx_reg  <= {rx_reg[15:0], data_s};
        cnt_reg <= (state_reg == DCW_IDLE) ? 5'h01 : cnt_reg + 5'h01;
      end
      // Ack only where a bit is taken or given; a refused start gets none
      if (req_rise && (state_next == DCW_RECV || state_reg == DCW_RECV ||
                       state_reg == DCW_RESP))
        ack_reg <= 1'b1;
      else if (req_fall)
        ack_reg <= 1'b0;
      // Arms the response shift, so the trailing fall of the command's
      // last bit is never taken as a response bit
      if (req_rise && state_reg == DCW_RESP)
        arm_reg <= 1'b1;
      else if (req_fall)
        arm_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Execution and seek storage
  // ----------------------------------------------------------------
  wire logic exec    = (state_reg == DCW_EXEC);
  wire logic set_hi  = exec && !reject && (func == dcw_pkg::DCW_SET_HIGH);
  wire logic do_seek = exec && !reject && (func == dcw_pkg::DCW_SEEK);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      high_reg       <= 4'h0;
      dir_reg        <= 2'h0;
      cmd_valid      <= 1'b0;
      cmd_invalid    <= 1'b0;
      parity_error   <= 1'b0;
      seek_valid     <= 1'b0;
      resp_sel_valid <= 1'b0;
      cmd_out        <= '0;
      seek_out       <= '0;
      resp_sel       <= 4'h0;
      resp_sub       <= 8'h00;
    end
    else
    begin
      cmd_valid      <= exec && !reject;
      cmd_invalid    <= exec && reject;
      parity_error   <= exec && par_bad;
      seek_valid     <= do_seek;
      resp_sel_valid <= tx_load;
      if (exec)
        cmd_out <= '{func, modif, subsc, parm};
      if (set_hi)
      begin
        // Kept until the next set-high command
        high_reg <= parm[3:0];
        dir_reg  <= modif[1:0];
      end
      if (do_seek)
      begin
        seek_out.target        <= optical_mode ?
                                  {high_reg, parm} : {4'h0, parm};
        seek_out.direction     <= optical_mode ? dir_reg : 2'h0;
        seek_out.clear_offsets <= !optical_mode;
      end
      if (tx_load)
      begin
        resp_sel <= modif;
        resp_sub <= subsc;
      end
    end
  end

  // Response word must arrive with reserved bits zeroed by its source
  assign xfer_ack     = ack_reg;
  assign status_data  = tx_busy && tx_bit;
  assign cmd_complete = (state_reg == DCW_IDLE) && drive_ready;
  assign high_bits    = high_reg;
  assign high_dir     = dir_reg;

endmodule : dcw_decoder

// [dcw_sva.sv]
`timescale 1ns/100ps
module dcw_sva (
  input wire logic               sys_clk,
  input wire logic               nrst,
  input wire logic               optical_mode,
  input wire logic               xfer_req_pin,
  input wire logic               xfer_ack,
  input wire logic               cmd_complete,
  input wire logic               cmd_valid,
  input wire dcw_pkg::dcw_cmd_t  cmd_out,
  input wire logic               cmd_invalid,
  input wire logic               parity_error,
  input wire logic               seek_valid,
  input wire dcw_pkg::dcw_seek_t seek_out,
  input wire logic [3:0]         high_bits,
  input wire logic [1:0]         high_dir,
  input wire logic               resp_sel_valid,
  input wire logic [3:0]         resp_sel
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // Reserved codes differ per variant, so decode them once here
  wire [3:0] f = cmd_out.func;
  wire rsv_m = f >= 4'hb && f != 4'he;
  wire rsv_o = f == 4'h4 || f == 4'h9 || f == 4'hc || f == 4'hd || f == 4'hf;
  wire rsv = optical_mode ? rsv_o : rsv_m;

  a_no_reserved: assert property (cmd_valid |-> !rsv)
    else $error("reserved code executed");
  a_bad_parity: assert property (parity_error |-> cmd_invalid && !cmd_valid)
    else $error("parity failure not rejected");
  a_invalid_quiet: assert property (cmd_invalid |-> !seek_valid)
    else $error("rejected command acted on");
  a_mag_seek: assert property (seek_valid && !optical_mode |-> f == 4'h0 && seek_out.clear_offsets && seek_out.target == {4'h0, cmd_out.parameter_f})
    else $error("magnetic seek wrong");
  a_opt_seek: assert property (seek_valid && optical_mode |-> f == 4'h0 && seek_out.direction == high_dir && seek_out.target == {high_bits, cmd_out.parameter_f})
    else $error("optical seek wrong");
  a_high_cause: assert property ($changed({high_bits, high_dir}) |-> ##[0:1] (cmd_valid && f == 4'ha))
    else $error("high bits changed without set");
  a_resp_select: assert property (resp_sel_valid |-> ##[0:1] (cmd_valid && resp_sel == cmd_out.modifier))
    else $error("response select mismatch");
  a_ack_cause: assert property ($rose(xfer_ack) |-> $past(xfer_req_pin))
    else $error("ack without request");
  a_busy_frame: assert property ($rose(xfer_ack) |=> !cmd_complete)
    else $error("complete during transfer");
endmodule : dcw_sva

bind dcw_decoder dcw_sva u_sva (.sys_clk, .nrst, .optical_mode, .xfer_req_pin,
  .xfer_ack, .cmd_complete, .cmd_valid, .cmd_out, .cmd_invalid, .parity_error,
  .seek_valid, .seek_out, .high_bits, .high_dir, .resp_sel_valid, .resp_sel);

// [dcw_host.sv]
`timescale 1ns/100ps
module dcw_host (
  input  wire logic sys_clk,
  input  wire logic xfer_ack,
  input  wire logic status_data,
  output logic      cmd_data,
  output logic      xfer_req
);
  int stuck = 0;

  // Idle lines at time zero
  initial
  begin
    cmd_data = 1'b0;
    xfer_req = 1'b0;
  end

  // One bit: hold data and request until ack, then release both
  task automatic xfer(input logic d, output logic s);
    int n;
    cmd_data <= d;
    xfer_req <= 1'b1;
    n = 0;
    do @(posedge sys_clk); while (!xfer_ack && ++n < 40);
    s = status_data;
    xfer_req <= 1'b0;
    cmd_data <= ~d; // Released line must not keep the bit
    if (n >= 40) stuck++;
    n = 0;
    do @(posedge sys_clk); while (xfer_ack && ++n < 40);
    if (n >= 40) stuck++;
  endtask : xfer

  // Whole frame, bit 16 first, parity last
  task automatic frame(input logic [16:0] w, output logic [16:0] s);
    for (int i = 16; i >= 0; i--)
      xfer(w[i], s[i]);
  endtask : frame
endmodule : dcw_host

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic optical_mode = 1'b0;
  logic drive_ready = 1'b0;
  logic [15:0] resp_word = 16'h0000;
  logic cmd_data_pin, xfer_req_pin, xfer_ack, status_data, resp_sel_valid;
  logic cmd_complete, cmd_valid, cmd_invalid, parity_error, seek_valid;
  logic [3:0] resp_sel, high_bits;
  logic [7:0] resp_sub;
  logic [1:0] high_dir;
  dcw_pkg::dcw_cmd_t cmd_out, g_c;
  dcw_pkg::dcw_seek_t seek_out, g_s;
  logic g_i, g_pe, g_sv;
  logic [3:0] g_sel;
  logic [7:0] g_sub;
  int g_n = 0;
  int err_count = 0;
  int check_count = 0;

  always #50 sys_clk = ~sys_clk;

  dcw_decoder u_dut (.sys_clk, .nrst, .optical_mode, .cmd_data_pin,
    .xfer_req_pin, .xfer_ack, .status_data, .drive_ready, .resp_word,
    .resp_sel_valid, .resp_sel, .resp_sub, .cmd_complete, .cmd_valid,
    .cmd_out, .cmd_invalid, .parity_error, .seek_valid, .seek_out,
    .high_bits, .high_dir);
  dcw_host u_host (.sys_clk, .xfer_ack, .status_data,
    .cmd_data(cmd_data_pin), .xfer_req(xfer_req_pin));

  // Pulses last one cycle, so latch them for the end of frame checks
  always @(posedge sys_clk)
  begin
    if (cmd_valid | cmd_invalid)
    begin
      g_n <= g_n + 1;
      g_i <= cmd_invalid;
      g_pe <= parity_error;
      g_sv <= seek_valid;
      g_c <= cmd_out;
      g_s <= seek_out;
    end
    if (resp_sel_valid)
    begin
      g_sel <= resp_sel;
      g_sub <= resp_sub;
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  function automatic bit rsv(input bit o, input logic [3:0] f);
    if (o)
      return f == 4 || f == 9 || f == 12 || f == 13 || f == 15;
    return f >= 11 && f != 14;
  endfunction : rsv

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Main sequence: optical map first, then magnetic
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] sd;
    logic [16:0] st;
    logic [11:0] p;
    logic [3:0] f, hb;
    logic [1:0] hd;
    logic bad, ei, b;
    int n0;
    sd = 32'h8bd27826;
    hb = 4'h0;
    hd = 2'h0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    u_host.xfer(1'b1, b);
    chk("ignored", u_host.stuck, 1);
    u_host.stuck = 0;
    drive_ready <= 1'b1;
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 18; i++)
      begin
        sd = nxt(sd);
        f = i[3:0];
        p = sd[11:0] & ((f == 0 || f == 2 || f == 10) ? 12'hfff : 12'hf00);
        bad = (i == 17);
        ei = bad || rsv(m == 0, f);
        optical_mode <= (m == 0);
        resp_word <= sd[31:16];
        n0 = g_n;
        u_host.frame({f, p, ~(^{f, p}) ^ bad}, st);
        if (!ei && (f == 2 || f == 3))
          u_host.frame(17'h00000, st);
        chk("pulses", g_n - n0, 1);
        chk("invalid", g_i, ei);
        chk("parity", g_pe, bad);
        if (!ei)
        begin
          chk("fields", g_c, {f, p[11:8], p[7:0], p});
          chk("seek", g_sv, f == 0);
          if (f == 0 && m == 0)
            chk("dir", g_s.direction, hd);
          if (f == 0 && m == 1)
            chk("clear", g_s.clear_offsets, 1);
          if (f == 0)
            chk("target", g_s.target, {m ? 4'h0 : hb, p});
          if (f == 2 || f == 3)
            chk("status", st, {resp_word, ~(^resp_word)});
          if (f == 2 || f == 3)
            chk("select", g_sel, p[11:8]);
          if (f == 2 || f == 3)
            chk("subscript", g_sub, p[7:0]);
          if (f == 10 && m == 0)
          begin
            hb = p[3:0];
            hd = p[9:8];
          end
        end
        chk("stall", u_host.stuck, 0);
        if (u_host.stuck != 0)
          test_done();
      end
    test_done();
  end
endmodule : tb_top
